// ### design/motion_status_pkg.sv
// Shared constants and carriers for the host status word bank
package motion_status_pkg;
  localparam int WORD_W      = 16;
  localparam int ADDR_W      = 8;
  localparam int AXIS_CNT    = 4;
  localparam int AXIS_IDX_W  = 2;
  localparam int TASK_CNT    = 5;
  localparam int DIN_CNT     = 24;
  localparam int DIN_LO_CNT  = 8;
  localparam int DOUT_CNT    = 16;
  localparam int AX_BYTE_W   = 8;
  localparam int CFG_FIELD_W = 2;
  localparam int SYNC_W      = DIN_CNT + 2 * AXIS_CNT;

  // Word offsets
  localparam logic [ADDR_W-1:0] OFS_UNIT     = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_DIN_HI   = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_DOUT     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_AX01     = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_AX23     = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_FERR_CLR = 8'h12;
  localparam logic [ADDR_W-1:0] OFS_CFG_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] CFG_SPAN     = 8'h10;

  // Unit word fields
  localparam int BIT_RUN    = 0;
  localparam int BIT_SERVO  = 1;
  localparam int BIT_TASK0  = 2;
  localparam int BIT_XFER   = 7;
  localparam int BIT_DIN_LO = 8;

  // Axis byte fields
  localparam int AX_WARN   = 0;
  localparam int AX_FWD_HW = 1;
  localparam int AX_REV_HW = 2;
  localparam int AX_HOME   = 3;
  localparam int AX_HOLD   = 4;
  localparam int AX_FERR   = 5;
  localparam int AX_FWD_SW = 6;
  localparam int AX_REV_SW = 7;

  // Config fields inside one axis slot
  localparam logic [CFG_FIELD_W-1:0] CFG_WARN   = 2'h0;
  localparam logic [CFG_FIELD_W-1:0] CFG_ERR    = 2'h1;
  localparam logic [CFG_FIELD_W-1:0] CFG_SW_FWD = 2'h2;
  localparam logic [CFG_FIELD_W-1:0] CFG_SW_REV = 2'h3;

  // Interrupt status bits
  localparam int IRQ_SERVO  = 0;
  localparam int IRQ_FERR   = 1;
  localparam int IRQ_HW_LIM = 2;
  localparam int IRQ_SW_LIM = 3;
  localparam int IRQ_W      = 4;

  localparam logic [WORD_W-1:0] WORD_ZERO  = 16'h0000;
  localparam logic [WORD_W-1:0] WARN_RST   = 16'hFFFF;
  localparam logic [WORD_W-1:0] ERR_RST    = 16'hFFFF;
  localparam logic [WORD_W-1:0] SW_FWD_RST = 16'h7FFF;
  localparam logic [WORD_W-1:0] SW_REV_RST = 16'h8000;

  typedef struct packed {
    logic [WORD_W-1:0]        warn_lim;
    logic [WORD_W-1:0]        err_lim;
    logic signed [WORD_W-1:0] sw_fwd;
    logic signed [WORD_W-1:0] sw_rev;
  } axis_cfg_t;

  typedef struct packed {
    logic [WORD_W-1:0]        err_mag;
    logic signed [WORD_W-1:0] pos;
    logic                     home_busy;
    logic                     hold;
  } axis_live_t;

  typedef struct packed {
    logic                   hit;
    logic [AXIS_IDX_W-1:0]  axis;
    logic [CFG_FIELD_W-1:0] field;
  } cfg_sel_t;

  localparam axis_cfg_t CFG_RST = '{
    warn_lim: WARN_RST, err_lim: ERR_RST, sw_fwd: SW_FWD_RST, sw_rev: SW_REV_RST};
endpackage

// ### design/pin_sync.sv
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         core_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next.meta = pin_i;
    st_next.safe = st_reg.meta;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.safe;
endmodule

// ### design/axis_flag_builder.sv
// Combinational flag byte for one axis
`timescale 1ns/1ps
module axis_flag_builder (
  input  motion_status_pkg::axis_cfg_t              cfg_i,
  input  motion_status_pkg::axis_live_t             live_i,
  input  wire logic                                 fwd_hw_i,
  input  wire logic                                 rev_hw_i,
  input  wire logic                                 ferr_latched_i,
  output logic [motion_status_pkg::AX_BYTE_W-1:0]   flags_o,
  output logic                                      ferr_over_o
);
  import motion_status_pkg::*;

  assign ferr_over_o = live_i.err_mag > cfg_i.err_lim;

  always_comb begin
    flags_o            = '0;
    flags_o[AX_WARN]   = live_i.err_mag > cfg_i.warn_lim; // R8
    flags_o[AX_FWD_HW] = fwd_hw_i;                        // R9
    flags_o[AX_REV_HW] = rev_hw_i;                        // R10
    flags_o[AX_HOME]   = live_i.home_busy;                // R11
    flags_o[AX_HOLD]   = live_i.hold;                     // R12
    flags_o[AX_FERR]   = ferr_latched_i | ferr_over_o;    // R13
    flags_o[AX_FWD_SW] = live_i.pos > cfg_i.sw_fwd;       // R14
    flags_o[AX_REV_SW] = live_i.pos < cfg_i.sw_rev;       // R15
  end
endmodule

// ### design/motion_status_bank.sv
// Host-visible status word bank of the motion unit
`timescale 1ns/1ps
//
// Operation
// R1: Unit word bit 0 is high while the unit runs.
// R2: Unit word bit 1 is high while any motion or servo error exists.
// R3: Unit word bits 2 to 6 show tasks one to five active.
// R4: Unit word bit 7 is high during a host data exchange.
// R5: Unit word bits 8 to 15 mirror digital inputs 0 to 7.
// R6: Second word carries digital inputs 8 to 23, lowest in bit 0.
// R7: Third word carries digital outputs 0 to 15, lowest in bit 0.
// R8: Axis bit 0 set when position error exceeds warning threshold.
// R9: Axis bit 1 set while forward travel limit input is active.
// R10: Axis bit 2 set while reverse travel limit input is active.
// R11: Axis bit 3 high while a home search runs on that axis.
// R12: Axis bit 4 set while a motion hold is asserted.
// R13: Axis bit 5 set once position error passed the hard limit.
// R14: Axis bit 6 set when position passed forward software limit.
// R15: Axis bit 7 set when position passed reverse software limit.
// R16: Word at offset six holds axis 2 low byte, axis 3 high.
// R17: Another word holds axis 0 low byte, axis 1 high.
// R18: Host supplies two command words at base and base plus one; this bank decodes and stores no command words.
// R19: Status words refresh from live state each cycle; host cannot write.
module motion_status_bank (
  input  wire logic                                        core_clk_i,
  input  wire logic                                        arst_n_i,
  input  wire logic [motion_status_pkg::ADDR_W-1:0]        reg_addr_i,
  input  wire logic [motion_status_pkg::WORD_W-1:0]        reg_wdata_i,
  input  wire logic                                        reg_wr_i,
  input  wire logic                                        reg_rd_i,
  output logic      [motion_status_pkg::WORD_W-1:0]        reg_rdata_o,
  output logic                                             irq_o,
  input  wire logic                                        unit_run_i,
  input  wire logic                                        servo_err_i,
  input  wire logic [motion_status_pkg::TASK_CNT-1:0]      task_active_i,
  input  wire logic                                        xfer_busy_i,
  input  wire logic [motion_status_pkg::DIN_CNT-1:0]       din_pin_i,
  input  wire logic [motion_status_pkg::DOUT_CNT-1:0]      dout_state_i,
  input  wire logic [motion_status_pkg::AXIS_CNT-1:0]      fwd_limit_pin_i,
  input  wire logic [motion_status_pkg::AXIS_CNT-1:0]      rev_limit_pin_i,
  input  motion_status_pkg::axis_live_t [motion_status_pkg::AXIS_CNT-1:0] axis_live_i
);
  import motion_status_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0]               w_unit;
    logic [WORD_W-1:0]               w_din_hi;
    logic [WORD_W-1:0]               w_dout;
    logic [WORD_W-1:0]               w_ax01;
    logic [WORD_W-1:0]               w_ax23;
    logic [AXIS_CNT-1:0]             ferr_latch;
    logic [IRQ_W-1:0]                irq_stat;
    logic [IRQ_W-1:0]                irq_mask;
    axis_cfg_t [AXIS_CNT-1:0]        cfg;
    logic [WORD_W-1:0]               rdata;
  } bank_state_t;

  localparam bank_state_t ST_RST = '{
    w_unit:     WORD_ZERO,
    w_din_hi:   WORD_ZERO,
    w_dout:     WORD_ZERO,
    w_ax01:     WORD_ZERO,
    w_ax23:     WORD_ZERO,
    ferr_latch: '0,
    irq_stat:   '0,
    irq_mask:   '0,
    cfg:        {AXIS_CNT{CFG_RST}},
    rdata:      WORD_ZERO
  };

  bank_state_t                  st_reg;
  bank_state_t                  st_next;
  logic [SYNC_W-1:0]            pin_raw;
  logic [SYNC_W-1:0]            pin_safe;
  logic [DIN_CNT-1:0]           din_sync;
  logic [AXIS_CNT-1:0]          fwd_sync;
  logic [AXIS_CNT-1:0]          rev_sync;
  logic [AX_BYTE_W-1:0]         ax_byte [AXIS_CNT];
  logic [AXIS_CNT-1:0]          ferr_over;
  logic [WORD_W-1:0]            unit_word;
  logic [WORD_W-1:0]            ax01_word;
  logic [WORD_W-1:0]            ax23_word;
  logic [AXIS_CNT-1:0]          hw_now;
  logic [AXIS_CNT-1:0]          hw_was;
  logic [AXIS_CNT-1:0]          sw_now;
  logic [AXIS_CNT-1:0]          sw_was;
  logic [IRQ_W-1:0]             irq_event;
  cfg_sel_t                     wr_sel;
  cfg_sel_t                     rd_sel;

  // Maps an address onto one axis configuration slot
  function automatic cfg_sel_t cfg_decode(input logic [ADDR_W-1:0] a);
    cfg_sel_t             s;
    logic [ADDR_W-1:0]    rel;
    rel     = a - OFS_CFG_BASE;
    s.hit   = (a >= OFS_CFG_BASE) && (rel < CFG_SPAN);
    s.axis  = rel[CFG_FIELD_W +: AXIS_IDX_W];
    s.field = rel[CFG_FIELD_W-1:0];
    return s;
  endfunction

  // Reads one field of an axis configuration slot
  function automatic logic [WORD_W-1:0] cfg_field(
    input axis_cfg_t              c,
    input logic [CFG_FIELD_W-1:0] f
  );
    logic [WORD_W-1:0] v;
    v = WORD_ZERO;
    case (f)
      CFG_WARN:   v = c.warn_lim;
      CFG_ERR:    v = c.err_lim;
      CFG_SW_FWD: v = c.sw_fwd;
      CFG_SW_REV: v = c.sw_rev;
      default:    v = WORD_ZERO;
    endcase
    return v;
  endfunction

  // Limit switches and digital inputs come straight from pins
  assign pin_raw = {rev_limit_pin_i, fwd_limit_pin_i, din_pin_i};

  pin_sync #(
    .W (SYNC_W)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .pin_i      (pin_raw),
    .sync_o     (pin_safe)
  );

  assign din_sync = pin_safe[DIN_CNT-1:0];
  assign fwd_sync = pin_safe[DIN_CNT +: AXIS_CNT];
  assign rev_sync = pin_safe[DIN_CNT + AXIS_CNT +: AXIS_CNT];

  genvar gi;
  generate
    for (gi = 0; gi < AXIS_CNT; gi++) begin : g_axis
      axis_flag_builder u_axis (
        .cfg_i          (st_reg.cfg[gi]),
        .live_i         (axis_live_i[gi]),
        .fwd_hw_i       (fwd_sync[gi]),
        .rev_hw_i       (rev_sync[gi]),
        .ferr_latched_i (st_reg.ferr_latch[gi]),
        .flags_o        (ax_byte[gi]),
        .ferr_over_o    (ferr_over[gi])
      );
      assign hw_now[gi] = ax_byte[gi][AX_FWD_HW] | ax_byte[gi][AX_REV_HW];
      assign sw_now[gi] = ax_byte[gi][AX_FWD_SW] | ax_byte[gi][AX_REV_SW];
    end
  endgenerate

  assign ax01_word = {ax_byte[1], ax_byte[0]}; // R17
  assign ax23_word = {ax_byte[3], ax_byte[2]}; // R16

  // Previous levels, taken from the words the host last saw
  always_comb begin
    for (int i = 0; i < AXIS_CNT; i++) begin
      if (i < AXIS_CNT / 2) begin
        hw_was[i] = st_reg.w_ax01[i * AX_BYTE_W + AX_FWD_HW]
                  | st_reg.w_ax01[i * AX_BYTE_W + AX_REV_HW];
        sw_was[i] = st_reg.w_ax01[i * AX_BYTE_W + AX_FWD_SW]
                  | st_reg.w_ax01[i * AX_BYTE_W + AX_REV_SW];
      end else begin
        hw_was[i] = st_reg.w_ax23[(i - AXIS_CNT / 2) * AX_BYTE_W + AX_FWD_HW]
                  | st_reg.w_ax23[(i - AXIS_CNT / 2) * AX_BYTE_W + AX_REV_HW];
        sw_was[i] = st_reg.w_ax23[(i - AXIS_CNT / 2) * AX_BYTE_W + AX_FWD_SW]
                  | st_reg.w_ax23[(i - AXIS_CNT / 2) * AX_BYTE_W + AX_REV_SW];
      end
    end
  end

  always_comb begin
    unit_word                           = WORD_ZERO;
    unit_word[BIT_RUN]                  = unit_run_i;                          // R1
    unit_word[BIT_SERVO]                = servo_err_i | (|st_reg.ferr_latch);  // R2
    unit_word[BIT_TASK0 +: TASK_CNT]    = task_active_i;                       // R3
    unit_word[BIT_XFER]                 = xfer_busy_i;                         // R4
    unit_word[BIT_DIN_LO +: DIN_LO_CNT] = din_sync[DIN_LO_CNT-1:0];            // R5
  end

  // Rising conditions that raise interrupt status
  always_comb begin
    irq_event             = '0;
    irq_event[IRQ_SERVO]  = unit_word[BIT_SERVO] & ~st_reg.w_unit[BIT_SERVO];
    irq_event[IRQ_FERR]   = |(ferr_over & ~st_reg.ferr_latch);
    irq_event[IRQ_HW_LIM] = |(hw_now & ~hw_was);
    irq_event[IRQ_SW_LIM] = |(sw_now & ~sw_was);
  end

  assign wr_sel = cfg_decode(reg_addr_i);
  assign rd_sel = cfg_decode(reg_addr_i);

  always_comb begin
    st_next = st_reg;

    // Host view refreshes every cycle; writes to these words are dropped
    st_next.w_unit   = unit_word;                               // R19
    st_next.w_din_hi = din_sync[DIN_CNT-1:DIN_LO_CNT];          // R6
    st_next.w_dout   = dout_state_i;                            // R7
    st_next.w_ax01   = ax01_word;                               // R17
    st_next.w_ax23   = ax23_word;                               // R16

    // Hard-limit latch: new excess wins over a same-cycle clear
    if (reg_wr_i && (reg_addr_i == OFS_FERR_CLR)) begin
      st_next.ferr_latch = st_reg.ferr_latch & ~reg_wdata_i[AXIS_CNT-1:0];
    end
    st_next.ferr_latch = st_next.ferr_latch | ferr_over;        // R13

    if (reg_wr_i && (reg_addr_i == OFS_IRQ_MASK)) begin
      st_next.irq_mask = reg_wdata_i[IRQ_W-1:0];
    end

    if (reg_wr_i && wr_sel.hit) begin
      case (wr_sel.field)
        CFG_WARN:   st_next.cfg[wr_sel.axis].warn_lim = reg_wdata_i;
        CFG_ERR:    st_next.cfg[wr_sel.axis].err_lim  = reg_wdata_i;
        CFG_SW_FWD: st_next.cfg[wr_sel.axis].sw_fwd   = reg_wdata_i;
        CFG_SW_REV: st_next.cfg[wr_sel.axis].sw_rev   = reg_wdata_i;
        default:    st_next.cfg[wr_sel.axis].warn_lim = st_reg.cfg[wr_sel.axis].warn_lim;
      endcase
    end

    // Read of status clears it, but an event in that cycle survives
    if (reg_rd_i && (reg_addr_i == OFS_IRQ_STAT)) begin
      st_next.irq_stat = '0;
    end
    st_next.irq_stat = st_next.irq_stat | irq_event;

    // Read data stand only in the cycle after the strobe
    st_next.rdata = WORD_ZERO;
    if (reg_rd_i) begin
      if (rd_sel.hit) begin
        st_next.rdata = cfg_field(st_reg.cfg[rd_sel.axis], rd_sel.field);
      end else begin
        case (reg_addr_i)
          OFS_UNIT:     st_next.rdata = st_reg.w_unit;
          OFS_DIN_HI:   st_next.rdata = st_reg.w_din_hi;
          OFS_DOUT:     st_next.rdata = st_reg.w_dout;
          OFS_AX01:     st_next.rdata = st_reg.w_ax01;
          OFS_AX23:     st_next.rdata = st_reg.w_ax23;
          OFS_IRQ_STAT: st_next.rdata = {{(WORD_W - IRQ_W){1'b0}}, st_reg.irq_stat};
          OFS_IRQ_MASK: st_next.rdata = {{(WORD_W - IRQ_W){1'b0}}, st_reg.irq_mask};
          OFS_FERR_CLR: st_next.rdata = {{(WORD_W - AXIS_CNT){1'b0}}, st_reg.ferr_latch};
          default:      st_next.rdata = WORD_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign irq_o       = |(st_reg.irq_stat & st_reg.irq_mask);
endmodule

// ### testbench/motion_status_bank_checker.sv
// Port-level assertions for the host status word bank
`timescale 1ns/1ps
module motion_status_bank_checker (
  input wire logic                                        core_clk_i,
  input wire logic                                        arst_n_i,
  input wire logic [motion_status_pkg::ADDR_W-1:0]        reg_addr_i,
  input wire logic                                        reg_rd_i,
  input wire logic [motion_status_pkg::WORD_W-1:0]        reg_rdata_o,
  input wire logic                                        unit_run_i,
  input wire logic                                        servo_err_i,
  input wire logic [motion_status_pkg::TASK_CNT-1:0]      task_active_i,
  input wire logic                                        xfer_busy_i,
  input wire logic [motion_status_pkg::DIN_CNT-1:0]       din_pin_i,
  input wire logic [motion_status_pkg::DOUT_CNT-1:0]      dout_state_i,
  input motion_status_pkg::axis_live_t [motion_status_pkg::AXIS_CNT-1:0] axis_live_i
);
  import motion_status_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == WORD_ZERO)
    else $error("read data not zero outside a read answer");
  run_bit_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == OFS_UNIT
    |-> reg_rdata_o[BIT_RUN] == $past(unit_run_i, 2)) else $error("run bit wrong");
  servo_bit_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == OFS_UNIT
    && $past(servo_err_i, 2) |-> reg_rdata_o[BIT_SERVO]) else $error("error bit low");
  task_bits_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == OFS_UNIT
    |-> reg_rdata_o[6:2] == $past(task_active_i, 2)) else $error("task bits wrong");
  xfer_bit_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == OFS_UNIT
    |-> reg_rdata_o[BIT_XFER] == $past(xfer_busy_i, 2)) else $error("busy bit wrong");
  din_high_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == OFS_DIN_HI
    |-> reg_rdata_o == $past(din_pin_i[23:8], 4)) else $error("input word wrong");
  dout_word_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == OFS_DOUT
    |-> reg_rdata_o == $past(dout_state_i, 2)) else $error("output word wrong");
  hold_ax0_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == OFS_AX01
    |-> reg_rdata_o[AX_HOLD] == $past(axis_live_i[0].hold, 2)) else $error("hold bit wrong");
  home_ax2_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == OFS_AX23
    |-> reg_rdata_o[AX_HOME] == $past(axis_live_i[2].home_busy, 2)) else $error("home bit");
endmodule
bind motion_status_bank motion_status_bank_checker u_chk (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .unit_run_i(unit_run_i),
  .servo_err_i(servo_err_i), .task_active_i(task_active_i), .xfer_busy_i(xfer_busy_i),
  .din_pin_i(din_pin_i), .dout_state_i(dout_state_i), .axis_live_i(axis_live_i));

// ### testbench/host_cpu_model.sv
// Host controller model that reads and writes the status bank
`timescale 1ns/1ps
module host_cpu_model (
  input  wire logic                                 core_clk_i,
  input  wire logic [motion_status_pkg::WORD_W-1:0] reg_rdata_i,
  output logic      [motion_status_pkg::ADDR_W-1:0] reg_addr_o,
  output logic      [motion_status_pkg::WORD_W-1:0] reg_wdata_o,
  output logic                                      reg_wr_o,
  output logic                                      reg_rd_o
);
  import motion_status_pkg::*;
  // Command words of the host are not modelled; only status traffic is driven
  initial begin
    reg_addr_o = '0;
    reg_wdata_o = '0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Idle address and data show the inverse of the last value
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] q);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge core_clk_i);
    q = reg_rdata_i;
  endtask
endmodule

// ### testbench/motion_unit_host_status_words_bench.sv
// Self-checking bench for the host status word bank
`timescale 1ns/1ps
module motion_unit_host_status_words_bench;
  import motion_status_pkg::*;
  logic                      core_clk_i;
  logic                      arst_n_i;
  logic [ADDR_W-1:0]         reg_addr_i;
  logic [WORD_W-1:0]         reg_wdata_i;
  logic                      reg_wr_i;
  logic                      reg_rd_i;
  logic [WORD_W-1:0]         reg_rdata_o;
  logic                      irq_o;
  logic                      unit_run_i;
  logic                      servo_err_i;
  logic [TASK_CNT-1:0]       task_active_i;
  logic                      xfer_busy_i;
  logic [DIN_CNT-1:0]        din_pin_i;
  logic [DOUT_CNT-1:0]       dout_state_i;
  logic [AXIS_CNT-1:0]       fwd_limit_pin_i;
  logic [AXIS_CNT-1:0]       rev_limit_pin_i;
  axis_live_t [AXIS_CNT-1:0] axis_live_i;
  logic [WORD_W-1:0]         q;
  logic                      b;
  int                        errors;
  int                        checks_done;

  motion_status_bank dut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .unit_run_i(unit_run_i),
    .servo_err_i(servo_err_i), .task_active_i(task_active_i), .xfer_busy_i(xfer_busy_i),
    .din_pin_i(din_pin_i), .dout_state_i(dout_state_i), .fwd_limit_pin_i(fwd_limit_pin_i),
    .rev_limit_pin_i(rev_limit_pin_i), .axis_live_i(axis_live_i));
  host_cpu_model u_host (
    .core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));

  task automatic chk(input string name, input logic [WORD_W-1:0] seen,
                     input logic [WORD_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] exp);
    u_host.rd(a, q);
    chk($sformatf("word %h", a), q, exp);
  endtask
  task automatic set_ax(input int a, input logic [15:0] e, input logic [15:0] p,
                        input logic h, input logic d);
    axis_live_i[a] <= '{err_mag: e, pos: p, home_busy: h, hold: d};
  endtask
  task automatic report_and_stop();
    $display("Checks done %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #20000;
    errors++;
    report_and_stop();
  end
  initial begin
    errors = 0;
    checks_done = 0;
    arst_n_i = 1'b0;
    unit_run_i = 1'b0;
    servo_err_i = 1'b0;
    task_active_i = '0;
    xfer_busy_i = 1'b0;
    din_pin_i = '0;
    dout_state_i = '0;
    fwd_limit_pin_i = '0;
    rev_limit_pin_i = '0;
    axis_live_i = '0;
    repeat (8) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd_chk(OFS_UNIT, WORD_ZERO);
    rd_chk(OFS_CFG_BASE, WARN_RST);
    rd_chk(OFS_CFG_BASE + 8'h05, ERR_RST);
    rd_chk(OFS_CFG_BASE + 8'h06, SW_FWD_RST);
    rd_chk(OFS_CFG_BASE + 8'h0F, SW_REV_RST);
    rd_chk(OFS_IRQ_MASK, WORD_ZERO);
    rd_chk(8'h7F, WORD_ZERO);
    u_host.wr(OFS_UNIT, 16'hFFFF);
    rd_chk(OFS_UNIT, WORD_ZERO);
    // Two opposite patterns catch swapped or shifted bits
    for (int i = 0; i < 2; i++) begin
      b = i[0];
      unit_run_i <= ~b;
      servo_err_i <= b;
      task_active_i <= b ? 5'h0A : 5'h15;
      xfer_busy_i <= ~b;
      din_pin_i <= b ? 24'h3C96A5 : 24'hC3695A;
      dout_state_i <= b ? 16'hEDCB : 16'h1234;
      repeat (6) @(posedge core_clk_i);
      rd_chk(OFS_UNIT, {din_pin_i[7:0], xfer_busy_i, task_active_i, b, ~b});
      rd_chk(OFS_DIN_HI, din_pin_i[23:8]);
      rd_chk(OFS_DOUT, dout_state_i);
    end
    for (int a = 0; a < AXIS_CNT; a++) begin
      u_host.wr(OFS_CFG_BASE + 8'(4 * a), 16'h0010);
      u_host.wr(OFS_CFG_BASE + 8'(4 * a + 1), 16'h0100);
      u_host.wr(OFS_CFG_BASE + 8'(4 * a + 2), 16'h0100);
      u_host.wr(OFS_CFG_BASE + 8'(4 * a + 3), 16'hFF00);
    end
    servo_err_i <= 1'b0;
    fwd_limit_pin_i <= 4'h1;
    rev_limit_pin_i <= 4'h2;
    set_ax(0, 16'h0020, 16'h0200, 1'b0, 1'b0);
    set_ax(1, 16'h0005, 16'hFE00, 1'b1, 1'b0);
    set_ax(2, 16'h0000, 16'h0000, 1'b0, 1'b1);
    set_ax(3, 16'h0200, 16'h0000, 1'b0, 1'b0);
    repeat (6) @(posedge core_clk_i);
    rd_chk(OFS_AX01, 16'h8C43);
    rd_chk(OFS_AX23, 16'h2110);
    rd_chk(OFS_UNIT, {din_pin_i[7:0], 1'b0, task_active_i, 2'h2});
    rd_chk(OFS_CFG_BASE + 8'h0F, 16'hFF00);
    rd_chk(OFS_FERR_CLR, 16'h0008);
    u_host.wr(OFS_IRQ_MASK, 16'h0000);
    chk("irq masked", {15'h0, irq_o}, 16'h0000);
    u_host.wr(OFS_IRQ_MASK, 16'h000F);
    chk("irq raised", {15'h0, irq_o}, 16'h0001);
    rd_chk(OFS_IRQ_STAT, 16'h000F);
    chk("irq cleared", {15'h0, irq_o}, 16'h0000);
    rd_chk(OFS_IRQ_STAT, WORD_ZERO);
    set_ax(3, 16'h0000, 16'h0000, 1'b0, 1'b0);
    repeat (3) @(posedge core_clk_i);
    rd_chk(OFS_AX23, 16'h2010);
    u_host.wr(OFS_FERR_CLR, 16'h0008);
    rd_chk(OFS_AX23, 16'h0010);
    rd_chk(OFS_FERR_CLR, WORD_ZERO);
    report_and_stop();
  end
endmodule
